// file: cpt_cfg.svh
// Constants for the content-protection transmitter control register.
// Assumes inclusion by the control module only.
`ifndef CPT_CFG_SVH
`define CPT_CFG_SVH
`define CPT_CTL_ADDR 8'hC3
`define CPT_CTL_RESET 8'h00
`define CPT_BIT_ENGINE_RST 7
`define CPT_BIT_RSVD 6
`define CPT_BIT_LIST_OK 5
`define CPT_BIT_KEY_OK 4
`define CPT_BIT_ENC_OFF 3
`define CPT_BIT_ENC_ON 2
`define CPT_BIT_AUTH_OFF 1
`define CPT_BIT_AUTH_EN 0
`endif

// file: cpt_pkg.sv
// Types for the content-protection transmitter control register.
// Assumes no surroundings beyond the constants header.
package cpt_pkg;
  typedef enum logic [1:0] {
    CPT_POL_AUTHED = 2'b00,
    CPT_POL_REG = 2'b01,
    CPT_POL_ALWAYS = 2'b10,
    CPT_POL_PER_FRAME = 2'b11
  } cpt_policy_t;
  typedef enum logic [1:0] {
    CPT_VID_PLAIN = 2'b00,
    CPT_VID_ENCRYPT = 2'b01,
    CPT_VID_BLUE = 2'b10
  } cpt_video_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpt_reg_req_t;
  typedef struct packed {
    logic engine_reset;
    logic auth_start;
    logic auth_stop;
    logic key_approved;
    logic list_approved;
  } cpt_engine_cmd_t;
endpackage

// file: cpt_ctl.sv
// Control register of the content-protection transmitter and its effects.
// Assumes a register-access decoder on the same clock presenting requests.
`timescale 1ns/1ns
`default_nettype none
`include "cpt_cfg.svh"
module cpt_ctl (
  // Clock, reset and enable.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Register access.
  input wire cpt_pkg::cpt_reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Engine status and policy.
  input wire cpt_pkg::cpt_policy_t i_policy,
  input wire logic i_key_stored,
  input wire logic i_auth_fail,
  input wire logic i_authed,
  input wire logic i_list_done,
  input wire logic i_frame_encrypt,
  // Engine commands and video selection.
  output cpt_pkg::cpt_engine_cmd_t o_cmd,
  output logic o_receiver_key_ready_flag,
  output cpt_pkg::cpt_video_t o_video_mode
);
  logic wr_hit;
  logic rd_hit;
  logic auth_enabled_reg;
  logic encrypt_on_reg;
  logic key_approved_reg;
  logic list_approved_reg;
  logic plain_hold_reg;
  logic enc_eff;
  logic [7:0] ctl_view;
  assign wr_hit = i_req.wr && (i_req.addr == `CPT_CTL_ADDR);
  assign rd_hit = i_req.rd && (i_req.addr == `CPT_CTL_ADDR);
  assign enc_eff = (i_policy == cpt_pkg::CPT_POL_ALWAYS) ? 1'b1 :
                   (i_policy == cpt_pkg::CPT_POL_PER_FRAME) ?
                   i_frame_encrypt :
                   (i_policy == cpt_pkg::CPT_POL_AUTHED) ? 1'b1 :
                   encrypt_on_reg;
  assign ctl_view = {1'b0, 1'b0, list_approved_reg,
                     key_approved_reg, 1'b0,
                     (i_policy == cpt_pkg::CPT_POL_ALWAYS) ? 1'b1 :
                     encrypt_on_reg,
                     1'b0, auth_enabled_reg};

  // Authentication enable: set, restart, stop, engine reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      auth_enabled_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_hit && i_req.wdata[`CPT_BIT_ENGINE_RST]) begin
        auth_enabled_reg <= 1'b0;
      end else if (wr_hit && i_req.wdata[`CPT_BIT_AUTH_OFF]) begin
        auth_enabled_reg <= 1'b0;
      end else if (wr_hit && i_req.wdata[`CPT_BIT_AUTH_EN]) begin
        auth_enabled_reg <= 1'b1;
      end
    end
  end

  // Encryption enable bit, writable unless the policy is CPT_POL_ALWAYS.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      encrypt_on_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_hit && i_policy != cpt_pkg::CPT_POL_ALWAYS) begin
        encrypt_on_reg <= i_req.wdata[`CPT_BIT_ENC_ON];
      end
    end
  end

  // Receiver key approval: set by write of one, cleared by flag or reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      key_approved_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_hit && i_req.wdata[`CPT_BIT_ENGINE_RST]) begin
        key_approved_reg <= 1'b0;
      end else if (wr_hit && i_req.wdata[`CPT_BIT_KEY_OK]) begin
        key_approved_reg <= 1'b1;
      end else if (i_key_stored) begin
        key_approved_reg <= 1'b0;
      end
    end
  end

  // Downstream list approval holds until the sequence completes, authentication fails or an engine reset is written.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      list_approved_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_hit && i_req.wdata[`CPT_BIT_LIST_OK]) begin
        list_approved_reg <= 1'b1;
      end else if (i_list_done || i_auth_fail ||
                   (wr_hit && i_req.wdata[`CPT_BIT_ENGINE_RST])) begin
        list_approved_reg <= 1'b0;
      end
    end
  end

  // Key ready flag: the set wins over a simultaneous clear.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_receiver_key_ready_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_key_stored) begin
        o_receiver_key_ready_flag <= 1'b1;
      end else if (i_auth_fail || (wr_hit && i_req.wdata[`CPT_BIT_KEY_OK]) ||
                   (wr_hit && i_req.wdata[`CPT_BIT_ENGINE_RST])) begin
        o_receiver_key_ready_flag <= 1'b0;
      end
    end
  end

  // Plain-video hold from a one on bit 3 until encryption is re-enabled.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      plain_hold_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_hit && i_req.wdata[`CPT_BIT_ENC_OFF]) begin
        plain_hold_reg <= 1'b1;
      end else if (wr_hit && i_req.wdata[`CPT_BIT_ENC_ON]) begin
        plain_hold_reg <= 1'b0;
      end
    end
  end

  // Engine command pulses, one cycle each.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_cmd <= '0;
    end else if (i_ce) begin
      o_cmd.engine_reset <= wr_hit &&
                            i_req.wdata[`CPT_BIT_ENGINE_RST];
      o_cmd.auth_stop <= wr_hit && (i_req.wdata[`CPT_BIT_AUTH_OFF] ||
                         i_req.wdata[`CPT_BIT_ENGINE_RST]);
      o_cmd.auth_start <= wr_hit && i_req.wdata[`CPT_BIT_AUTH_EN] &&
                          !i_req.wdata[`CPT_BIT_AUTH_OFF] &&
                          !i_req.wdata[`CPT_BIT_ENGINE_RST];
      o_cmd.key_approved <= wr_hit && i_req.wdata[`CPT_BIT_KEY_OK];
      o_cmd.list_approved <= wr_hit && i_req.wdata[`CPT_BIT_LIST_OK];
    end
  end

  // Video path selection.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_video_mode <= cpt_pkg::CPT_VID_PLAIN;
    end else if (i_ce) begin
      if (!enc_eff || plain_hold_reg) begin
        o_video_mode <= cpt_pkg::CPT_VID_PLAIN;
      end else if (i_authed) begin
        o_video_mode <= cpt_pkg::CPT_VID_ENCRYPT;
      end else begin
        o_video_mode <= cpt_pkg::CPT_VID_BLUE;
      end
    end
  end

  // Read data, one cycle after the request.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rdata <= `CPT_CTL_RESET;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_req.rd;
      o_rdata <= rd_hit ? ctl_view : 8'h00;
    end
  end

  property p_reset_stops;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && wr_hit && i_req.wdata[`CPT_BIT_ENGINE_RST]) |=>
      (!auth_enabled_reg && o_cmd.engine_reset && o_cmd.auth_stop);
  endproperty
  a_reset_stops: assert property (p_reset_stops)
    else $error("Engine reset did not stop authentication.");

  property p_start;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && wr_hit && i_req.wdata[1:0] == 2'b01 &&
       !i_req.wdata[`CPT_BIT_ENGINE_RST]) |=>
      (auth_enabled_reg && o_cmd.auth_start);
  endproperty
  a_start: assert property (p_start)
    else $error("Start write did not enable authentication.");

  property p_stop;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && wr_hit && i_req.wdata[`CPT_BIT_AUTH_OFF]) |=> !auth_enabled_reg;
  endproperty
  a_stop: assert property (p_stop)
    else $error("Stop write left authentication enabled.");

  property p_forced_read;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && rd_hit && i_policy == cpt_pkg::CPT_POL_ALWAYS) |=>
      o_rdata[`CPT_BIT_ENC_ON];
  endproperty
  a_forced_read: assert property (p_forced_read)
    else $error("Forced encryption bit did not read one.");

  property p_rsvd;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_rvalid |-> (o_rdata[`CPT_BIT_RSVD] == 1'b0 && o_rdata[7] == 1'b0);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("Reserved or self-clearing bit read nonzero.");

  property p_flag_set;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && i_key_stored) |=> o_receiver_key_ready_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Key ready flag missed its set.");

  property p_key_clear;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && i_key_stored && !(wr_hit && |i_req.wdata[7:4])) |=>
      !key_approved_reg;
  endproperty
  a_key_clear: assert property (p_key_clear)
    else $error("Key approval not cleared by key ready.");

  property p_plain;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && (!enc_eff || plain_hold_reg)) |=>
      o_video_mode == cpt_pkg::CPT_VID_PLAIN;
  endproperty
  a_plain: assert property (p_plain)
    else $error("Video not plain with encryption off.");

  property p_blue;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_ce && enc_eff && !plain_hold_reg && !i_authed) |=>
      o_video_mode == cpt_pkg::CPT_VID_BLUE;
  endproperty
  a_blue: assert property (p_blue)
    else $error("Unauthenticated encrypted video not blue.");
endmodule
`default_nettype wire

// file: cpt_eng_model.sv
// Behavioural model of the protection engine beside the control block.
// Assumes the control block's command pulses on the same clock.
`timescale 1ns/1ns
`default_nettype none
module cpt_eng_model (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Commands in, status out.
  input wire cpt_pkg::cpt_engine_cmd_t i_cmd,
  output logic o_list_done,
  output logic o_authed
);
  logic [1:0] wait_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) wait_reg <= 2'h0;
    else wait_reg <= {wait_reg[0], i_cmd.list_approved};
  end
  assign o_list_done = wait_reg[1];
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_cmd.engine_reset || i_cmd.auth_stop ||
        i_cmd.auth_start) o_authed <= 1'b0;
    else if (o_list_done) o_authed <= 1'b1;
  end
endmodule
`default_nettype wire

// file: content_protect_tx_control_tb_top.sv
// Self-checking bench for the protection control register.
// Assumes the control block and the engine model on one 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module content_protect_tx_control_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ce = 1'b1;
  cpt_pkg::cpt_reg_req_t req = '0;
  cpt_pkg::cpt_policy_t pol = cpt_pkg::CPT_POL_REG;
  logic stored = 1'b0;
  logic fail = 1'b0;
  logic fenc = 1'b0;
  logic [7:0] o_rdata;
  logic o_rvalid, ldone, authed, flag;
  cpt_pkg::cpt_engine_cmd_t cmd, seen;
  cpt_pkg::cpt_video_t vid;
  logic [7:0] d;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  cpt_ctl dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_req(req), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_policy(pol),
    .i_key_stored(stored), .i_auth_fail(fail), .i_authed(authed),
    .i_list_done(ldone), .i_frame_encrypt(fenc), .o_cmd(cmd),
    .o_receiver_key_ready_flag(flag), .o_video_mode(vid));
  cpt_eng_model eng (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_cmd(cmd), .o_list_done(ldone), .o_authed(authed));
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      $display("ERROR t=%0t run did not finish in time", $time);
      close_out();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk_sys) req = '{1'b1, 1'b0, a, v};
    @(negedge i_clk_sys) req = '0;
    seen = cmd;
    @(negedge i_clk_sys) seen = seen | cmd;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    v = 8'hEE;
    @(negedge i_clk_sys) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_clk_sys) req = '0;
    for (int i = 0; i < 3; i++) begin
      if (o_rvalid === 1'b1) v = o_rdata;
      if (o_rvalid === 1'b1) break;
      @(negedge i_clk_sys);
    end
  endtask
  task automatic pulse(input logic sel_fail);
    @(negedge i_clk_sys);
    stored = !sel_fail;
    fail = sel_fail;
    @(negedge i_clk_sys);
    stored = 1'b0;
    fail = 1'b0;
    @(negedge i_clk_sys);
  endtask
  task automatic vchk(input cpt_pkg::cpt_video_t e);
    repeat (3) @(negedge i_clk_sys);
    chk({6'h00, vid}, {6'h00, e});
  endtask
  initial begin
    repeat (2) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    rd(8'hC3, d);
    chk(d, 8'h00);
    wr(8'hC3, 8'h01);
    chk({7'h00, seen.auth_start}, 8'h01);
    rd(8'hC3, d);
    chk(d, 8'h01);
    wr(8'hC3, 8'h01);
    chk({7'h00, seen.auth_start}, 8'h01);
    wr(8'hC3, 8'h00);
    wr(8'hC3, 8'h40);
    rd(8'hC3, d);
    chk(d, 8'h01);
    $display("test enable done");
    pulse(1'b0);
    chk({7'h00, flag}, 8'h01);
    wr(8'hC3, 8'h10);
    chk({7'h00, seen.key_approved}, 8'h01);
    chk({7'h00, flag}, 8'h00);
    rd(8'hC3, d);
    chk(d, 8'h11);
    pulse(1'b0);
    rd(8'hC3, d);
    chk(d, 8'h01);
    pulse(1'b1);
    chk({7'h00, flag}, 8'h00);
    wr(8'hC3, 8'h20);
    chk({7'h00, seen.list_approved}, 8'h01);
    rd(8'hC3, d);
    chk(d, 8'h21);
    repeat (5) @(negedge i_clk_sys);
    rd(8'hC3, d);
    chk(d, 8'h01);
    $display("test keys done");
    wr(8'hC3, 8'h04);
    vchk(cpt_pkg::CPT_VID_ENCRYPT);
    wr(8'hC3, 8'h0C);
    vchk(cpt_pkg::CPT_VID_PLAIN);
    rd(8'hC3, d);
    chk(d & 8'h0F, 8'h05);
    wr(8'hC3, 8'h04);
    vchk(cpt_pkg::CPT_VID_ENCRYPT);
    wr(8'hC3, 8'h06);
    chk({7'h00, seen.auth_stop}, 8'h01);
    rd(8'hC3, d);
    chk(d & 8'h03, 8'h00);
    vchk(cpt_pkg::CPT_VID_BLUE);
    wr(8'hC3, 8'h00);
    vchk(cpt_pkg::CPT_VID_PLAIN);
    $display("test video done");
    pol = cpt_pkg::CPT_POL_ALWAYS;
    wr(8'hC3, 8'h00);
    rd(8'hC3, d);
    chk(d & 8'h04, 8'h04);
    vchk(cpt_pkg::CPT_VID_BLUE);
    wr(8'hC3, 8'h04);
    pol = cpt_pkg::CPT_POL_REG;
    rd(8'hC3, d);
    chk(d & 8'h04, 8'h00);
    pol = cpt_pkg::CPT_POL_AUTHED;
    vchk(cpt_pkg::CPT_VID_BLUE);
    pol = cpt_pkg::CPT_POL_PER_FRAME;
    vchk(cpt_pkg::CPT_VID_PLAIN);
    fenc = 1'b1;
    vchk(cpt_pkg::CPT_VID_BLUE);
    $display("test policy done");
    ce = 1'b0;
    wr(8'hC3, 8'h01);
    ce = 1'b1;
    chk({7'h00, seen.auth_start}, 8'h00);
    rd(8'hC3, d);
    chk(d & 8'h01, 8'h00);
    $display("test enable freeze done");
    wr(8'hC3, 8'h01);
    wr(8'hC3, 8'h81);
    chk({7'h00, seen.engine_reset}, 8'h01);
    chk({7'h00, seen.auth_start}, 8'h00);
    rd(8'hC3, d);
    chk(d & 8'hC3, 8'h00);
    rd(8'h00, d);
    chk(d, 8'h00);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
